// *** csw_pkg.sv ***
// Constants, field positions and carrier types for the clock source switch.
package csw_pkg;

    // ==========================================================
    // Clock rate and oscillator settling times
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 25;
    // Software waits these times before it selects the oscillator.
    localparam int unsigned FAST_OSC_SETTLE_NS = 65000;
    localparam int unsigned MID_OSC_SETTLE_NS = 4000;
    localparam int unsigned SLOW_OSC_SETTLE_NS = 210000;
    localparam int unsigned FAST_OSC_SETTLE_CYC =
        (FAST_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MID_OSC_SETTLE_CYC =
        (MID_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOW_OSC_SETTLE_CYC =
        (SLOW_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Register byte addresses
    // ==========================================================
    localparam logic [11:0] ADDR_OSC_RUN = 12'h000;
    localparam logic [11:0] ADDR_SYS_SEL = 12'h004;
    localparam logic [11:0] ADDR_SUB_SRC = 12'h008;
    localparam logic [11:0] ADDR_SUB_SUPPLY = 12'h00c;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ORC_FAST_STOP = 0;
    localparam int ORC_MID_EN = 1;
    localparam int ORC_SUB_XTAL_STOP = 6;
    localparam int ORC_MAIN_XTAL_STOP = 7;
    localparam int SCS_PICK = 0;
    localparam int SCS_PICK_STAT = 1;
    localparam int SCS_MAIN_SEL = 4;
    localparam int SCS_MAIN_STAT = 5;
    localparam int SCS_CPU_SEL = 6;
    localparam int SCS_CPU_STAT = 7;
    localparam int SSS_SLOW_SEL = 0;
    localparam int SSM_TIMER_PICK = 4;
    localparam int SSM_LOW_POWER = 7;

    // Writable bits of each register except the system select; all other bits read as zero.
    localparam logic [7:0] ORC_WMASK = 8'hc3;
    localparam logic [7:0] SSS_WMASK = 8'h01;
    localparam logic [7:0] SSM_WMASK = 8'h90;

    // ==========================================================
    // Values after reset
    // ==========================================================
    // Both crystals stopped, fast internal oscillator running.
    localparam logic [7:0] ORC_RESET = 8'hc0;
    localparam logic [7:0] SSS_RESET = 8'h00;
    localparam logic [7:0] SSM_RESET = 8'h00;
    localparam logic SCS_PICK_RESET = 1'b0;
    localparam logic SCS_MAIN_RESET = 1'b0;
    localparam logic SCS_CPU_RESET = 1'b0;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic main_xtal;
        logic sub_xtal;
        logic slow;
        logic mid;
        logic fast;
    } csw_osc_t;

endpackage : csw_pkg

// *** csw_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/100ps

module csw_sync #(
    parameter int W = 5
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : csw_sync

// *** csw_clock_switch.sv ***
// Clock source switch: oscillator run control, source selects and status over APB.
//
// Function
// - Fast oscillator stop bit zero starts it.
// - Mid oscillator enable bit one starts it.
// - Main select clear picks internal oscillator clock.
// - Main source status bit; software checks before stop.
// - Main crystal stop bit one stops it.
// - Slow select starts slow oscillator, routes subsystem.
// - CPU select bit switches CPU to subsystem.
// - CPU source status bit shows subsystem active.
// - Timer pick bit clocks interval timer slowly.
// - Low power bit limits subsystem clock consumers in stop or halt on subsystem.
// - Sub crystal stop bit zero starts it.
`timescale 1ns/100ps

module csw_clock_switch (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire csw_pkg::csw_osc_t osc_ready,
    input wire logic stop_mode,
    input wire logic halt_mode,
    output csw_pkg::csw_osc_t osc_run,
    output logic main_from_crystal,
    output logic internal_pick_mid,
    output logic cpu_from_subsystem,
    output logic subsys_from_slow,
    output logic interval_timer_clock_pick,
    output logic subclk_periph_en
);

    // ==========================================================
    // Oscillator ready synchronisers
    // ==========================================================
    csw_pkg::csw_osc_t rdy;

    csw_sync #(
        .W(5)
    ) u_rdy_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d(osc_ready),
        .q(rdy)
    );

    // ==========================================================
    // APB decode
    // ==========================================================
    wire hit_orc = (paddr == csw_pkg::ADDR_OSC_RUN);
    wire hit_scs = (paddr == csw_pkg::ADDR_SYS_SEL);
    wire hit_sss = (paddr == csw_pkg::ADDR_SUB_SRC);
    wire hit_ssm = (paddr == csw_pkg::ADDR_SUB_SUPPLY);
    wire mapped = hit_orc | hit_scs | hit_sss | hit_ssm;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    // Only the low byte lane carries register data.
    wire wr_en = access & pwrite & pstrb[0] & mapped;
    wire wr_orc = wr_en & hit_orc;
    wire wr_scs = wr_en & hit_scs;
    wire wr_sss = wr_en & hit_sss;
    wire wr_ssm = wr_en & hit_ssm;
    wire [7:0] wbyte = pwdata[7:0];

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] orc_reg;
    logic [7:0] orc_next;
    logic [7:0] sss_reg;
    logic [7:0] sss_next;
    logic [7:0] ssm_reg;
    logic [7:0] ssm_next;
    logic pick_reg;
    logic pick_next;
    logic main_sel_reg;
    logic main_sel_next;
    logic cpu_sel_reg;
    logic cpu_sel_next;
    logic pick_stat_reg;
    logic pick_stat_next;
    logic main_stat_reg;
    logic main_stat_next;
    logic cpu_stat_reg;
    logic cpu_stat_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    assign orc_next = wr_orc ? (wbyte & csw_pkg::ORC_WMASK) : orc_reg;
    assign sss_next = wr_sss ? (wbyte & csw_pkg::SSS_WMASK) : sss_reg;
    assign ssm_next = wr_ssm ? (wbyte & csw_pkg::SSM_WMASK) : ssm_reg;
    assign pick_next = wr_scs ? wbyte[csw_pkg::SCS_PICK] : pick_reg;
    assign cpu_sel_next = wr_scs ? wbyte[csw_pkg::SCS_CPU_SEL] : cpu_sel_reg;
    // Changing the main select is refused while the CPU runs on the
    // subsystem clock, so the main path cannot glitch under a sleeping CPU.
    assign main_sel_next = (wr_scs && !cpu_stat_reg) ?
        wbyte[csw_pkg::SCS_MAIN_SEL] : main_sel_reg;

    // ==========================================================
    // Oscillator run outputs
    // ==========================================================
    wire fast_run = ~orc_reg[csw_pkg::ORC_FAST_STOP];
    wire mid_run = orc_reg[csw_pkg::ORC_MID_EN];
    wire main_xtal_run = ~orc_reg[csw_pkg::ORC_MAIN_XTAL_STOP];
    wire sub_xtal_run = ~orc_reg[csw_pkg::ORC_SUB_XTAL_STOP];
    wire slow_sel = sss_reg[csw_pkg::SSS_SLOW_SEL];
    wire timer_pick = ssm_reg[csw_pkg::SSM_TIMER_PICK];
    wire low_power = ssm_reg[csw_pkg::SSM_LOW_POWER];

    assign osc_run.fast = fast_run;
    assign osc_run.mid = mid_run;
    assign osc_run.main_xtal = main_xtal_run;
    assign osc_run.sub_xtal = sub_xtal_run;
    // The timer count clock keeps the slow oscillator alive on its own.
    assign osc_run.slow = slow_sel | timer_pick;

    // ==========================================================
    // Switch completion
    // ==========================================================
    // A select only takes effect once the target clock is running and
    // ready, so each status bit names a source that was live when it switched.
    wire fast_ok = fast_run & rdy.fast;
    wire mid_ok = mid_run & rdy.mid;
    wire xtal_ok = main_xtal_run & rdy.main_xtal;
    wire sub_ok = slow_sel ? rdy.slow : (sub_xtal_run & rdy.sub_xtal);
    wire pick_tgt_ok = pick_reg ? mid_ok : fast_ok;
    wire pick_cur_ok = pick_stat_reg ? mid_ok : fast_ok;
    wire main_tgt_ok = main_sel_reg ? xtal_ok : pick_cur_ok;
    wire main_cur_ok = main_stat_reg ? xtal_ok : pick_cur_ok;
    wire cpu_tgt_ok = cpu_sel_reg ? sub_ok : main_cur_ok;

    assign pick_stat_next = pick_tgt_ok ? pick_reg : pick_stat_reg;
    assign main_stat_next = main_tgt_ok ? main_sel_reg : main_stat_reg;
    assign cpu_stat_next = cpu_tgt_ok ? cpu_sel_reg : cpu_stat_reg;

    // ==========================================================
    // Read path
    // ==========================================================
    wire [7:0] scs_rd = {cpu_stat_reg, cpu_sel_reg, main_stat_reg, main_sel_reg,
        2'b00, pick_stat_reg, pick_reg};
    wire [7:0] rd_byte = hit_orc ? orc_reg :
                         hit_scs ? scs_rd :
                         hit_sss ? sss_reg :
                         hit_ssm ? ssm_reg : 8'h00;
    // Read data is captured in the setup cycle so it leaves a flip-flop.
    assign prdata_next = (setup && !pwrite) ? {24'h000000, rd_byte} : prdata_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            orc_reg <= csw_pkg::ORC_RESET;
            sss_reg <= csw_pkg::SSS_RESET;
            ssm_reg <= csw_pkg::SSM_RESET;
        end else begin
            orc_reg <= orc_next;
            sss_reg <= sss_next;
            ssm_reg <= ssm_next;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pick_reg <= csw_pkg::SCS_PICK_RESET;
            main_sel_reg <= csw_pkg::SCS_MAIN_RESET;
            cpu_sel_reg <= csw_pkg::SCS_CPU_RESET;
        end else begin
            pick_reg <= pick_next;
            main_sel_reg <= main_sel_next;
            cpu_sel_reg <= cpu_sel_next;
        end
    end

    // Status flip-flops only follow a select once its target is live.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pick_stat_reg <= csw_pkg::SCS_PICK_RESET;
            main_stat_reg <= csw_pkg::SCS_MAIN_RESET;
            cpu_stat_reg <= csw_pkg::SCS_CPU_RESET;
        end else begin
            pick_stat_reg <= pick_stat_next;
            main_stat_reg <= main_stat_next;
            cpu_stat_reg <= cpu_stat_next;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign main_from_crystal = main_stat_reg;
    assign internal_pick_mid = pick_stat_reg;
    assign cpu_from_subsystem = cpu_stat_reg;
    assign subsys_from_slow = slow_sel;
    assign interval_timer_clock_pick = timer_pick;
    // With the low power bit set, in stop, or halt on the subsystem clock, only
    // the real-time clock and the interval timer keep the subsystem clock.
    assign subclk_periph_en = ~(low_power & (stop_mode | (halt_mode & cpu_stat_reg)));

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_fast_osc_start: assert property (
        (access && pwrite && pstrb[0] && hit_orc && !pwdata[0]) |=> osc_run.fast)
        else $error("fast oscillator did not start after stop bit cleared");

    a_mid_osc_start: assert property (
        (access && pwrite && pstrb[0] && hit_orc && pwdata[1]) |=> osc_run.mid)
        else $error("mid oscillator did not start after enable set");

    a_main_xtal_stop: assert property (
        (access && pwrite && pstrb[0] && hit_orc && pwdata[7]) |=> !osc_run.main_xtal)
        else $error("main crystal still running after stop bit set");

    a_sub_xtal_start: assert property (
        (access && pwrite && pstrb[0] && hit_orc && !pwdata[6]) |=> osc_run.sub_xtal)
        else $error("sub crystal did not start after stop bit cleared");

    a_slow_sel_route: assert property (
        (access && pwrite && pstrb[0] && hit_sss && pwdata[0])
            |=> (osc_run.slow && subsys_from_slow))
        else $error("slow oscillator not started or routed");

    a_main_stat_follow: assert property (
        $changed(main_from_crystal) |-> (main_from_crystal == $past(main_sel_reg)))
        else $error("main source status moved away from its select");

    a_main_stat_live: assert property (
        $fell(main_from_crystal) |-> (!$past(main_sel_reg) && $past(pick_cur_ok)))
        else $error("main status left the crystal for an internal clock not ready");

    a_pick_stat_follow: assert property (
        $changed(internal_pick_mid) |-> ($past(pick_reg) == internal_pick_mid
            && $past(pick_tgt_ok)))
        else $error("internal pick status changed without a ready target");

    a_cpu_stat_rise: assert property (
        $rose(cpu_from_subsystem) |-> $past(cpu_sel_reg) && $past(sub_ok))
        else $error("CPU moved to subsystem without select and ready clock");

    a_cpu_stat_read: assert property (
        (setup && !pwrite && hit_scs) |=> (prdata[7] == $past(cpu_stat_reg)
            && prdata[5] == $past(main_stat_reg)))
        else $error("status bits read back wrongly");

    a_timer_pick: assert property (
        (access && pwrite && pstrb[0] && hit_ssm)
            |=> (interval_timer_clock_pick == $past(pwdata[4]) && osc_run.slow == 
            ($past(pwdata[4]) || subsys_from_slow)))
        else $error("interval timer clock pick not applied");

    a_subclk_gate: assert property (
        (ssm_reg[7] && stop_mode) |-> !subclk_periph_en)
        else $error("subsystem clock not limited in stop mode");

    a_reserved_zero: assert property (
        (setup && !pwrite && (hit_orc || hit_scs)) |=> (prdata[31:8] == 24'h000000
            && (($past(hit_orc) && prdata[5:2] == 4'h0)
            || ($past(hit_scs) && prdata[3:2] == 2'h0))))
        else $error("reserved bits read as non-zero");

    // Written fields take effect one cycle after the access edge.
    a_fast_osc_stop: assert property (
        (wr_orc && pwdata[0]) |=> !osc_run.fast)
        else $error("fast oscillator still running after stop bit set");

    a_mid_osc_stop: assert property (
        (wr_orc && !pwdata[1]) |=> !osc_run.mid)
        else $error("mid oscillator still running after enable cleared");

    a_main_xtal_start: assert property (
        (wr_orc && !pwdata[7]) |=> osc_run.main_xtal)
        else $error("main crystal did not start after stop bit cleared");

    a_sub_xtal_stop: assert property (
        (wr_orc && pwdata[6]) |=> !osc_run.sub_xtal)
        else $error("sub crystal still running after stop bit set");

    a_slow_sel_clear: assert property (
        (wr_sss && !pwdata[0]) |=> !subsys_from_slow)
        else $error("subsystem still routed from slow oscillator");

    a_pick_write: assert property (
        wr_scs |=> (pick_reg == $past(pwdata[0])))
        else $error("internal pick bit not written");

    a_pick_stat_live: assert property (
        $rose(internal_pick_mid) |-> $past(mid_ok))
        else $error("pick status moved to a mid oscillator that was not ready");

    a_main_sel_write: assert property (
        (wr_scs && !cpu_stat_reg) |=> (main_sel_reg == $past(pwdata[4])))
        else $error("main select bit not written");

    // The main select must not move while the CPU runs on the subsystem clock.
    a_main_sel_locked: assert property (
        (wr_scs && cpu_stat_reg) |=> (main_sel_reg == $past(main_sel_reg)))
        else $error("main select changed while CPU on subsystem clock");

    a_main_stat_rise: assert property (
        $rose(main_from_crystal) |-> ($past(main_sel_reg) && $past(xtal_ok)))
        else $error("main status names a crystal that was not ready");

    a_cpu_sel_write: assert property (
        wr_scs |=> (cpu_sel_reg == $past(pwdata[6])))
        else $error("CPU select bit not written");

    a_cpu_stat_fall: assert property (
        $fell(cpu_from_subsystem) |-> (!$past(cpu_sel_reg) && $past(main_cur_ok)))
        else $error("CPU left subsystem clock for a main clock not ready");

    a_subclk_free: assert property (
        !low_power |-> subclk_periph_en)
        else $error("subsystem clock withheld without low power bit");

    a_subclk_halt: assert property (
        (low_power && halt_mode && cpu_from_subsystem) |-> !subclk_periph_en)
        else $error("subsystem clock not limited in halt on subsystem clock");

    c_main_to_internal: cover property ($fell(main_from_crystal));
    c_cpu_to_sub: cover property ($rose(cpu_from_subsystem));
    c_pick_mid: cover property ($rose(internal_pick_mid));
    c_main_xtal_stopped: cover property (!main_from_crystal && $fell(osc_run.main_xtal));
    c_cpu_to_sub_xtal: cover property ($rose(cpu_from_subsystem) && !subsys_from_slow);

endmodule : csw_clock_switch

// *** tb_csw_clock_switch.sv ***
// Self-checking testbench for the clock source switch, driven over APB.
`timescale 1ns/100ps

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("[ERR] %s expected %h seen %h", nm, e, g); n_fail++; end end

module tb_csw_clock_switch;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    csw_pkg::csw_osc_t osc_ready = 5'h15;
    logic stop_mode = 1'b0;
    logic halt_mode = 1'b0;
    csw_pkg::csw_osc_t osc_run;
    logic main_from_crystal;
    logic internal_pick_mid;
    logic cpu_from_subsystem;
    logic subsys_from_slow;
    logic interval_timer_clock_pick;
    logic subclk_periph_en;
    int n_fail = 0;
    int cmp_count = 0;

    csw_clock_switch uut (
        .clock(clock),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_ready(osc_ready),
        .stop_mode(stop_mode),
        .halt_mode(halt_mode),
        .osc_run(osc_run),
        .main_from_crystal(main_from_crystal),
        .internal_pick_mid(internal_pick_mid),
        .cpu_from_subsystem(cpu_from_subsystem),
        .subsys_from_slow(subsys_from_slow),
        .interval_timer_clock_pick(interval_timer_clock_pick),
        .subclk_periph_en(subclk_periph_en)
    );

    always #12.5 clock = ~clock;

    // ==========================================================
    // Bus tasks
    // ==========================================================
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, 4'h1, q, e);
        `CHK("write error", 1'b0, e)
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 8'h00, 4'h0, q, e);
        `CHK("read data", {24'h00_0000, x}, q)
        `CHK("read error", 1'b0, e)
    endtask : rd

    // Status bits settle a few cycles after the target is ready, so poll.
    task automatic poll(input logic [11:0] a, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, a, 8'h00, 4'h0, q, e);
            if (q === {24'h00_0000, x}) break;
        end
        `CHK("polled data", {24'h00_0000, x}, q)
    endtask : poll

    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        close_out();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        logic [31:0] q;
        logic e;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rd(csw_pkg::ADDR_OSC_RUN, csw_pkg::ORC_RESET);
        rd(csw_pkg::ADDR_SYS_SEL, 8'h00);
        rd(csw_pkg::ADDR_SUB_SRC, 8'h00);
        rd(csw_pkg::ADDR_SUB_SUPPLY, 8'h00);
        `CHK("osc run", 5'h01, osc_run)
        apb(1'b0, 12'h010, 8'h00, 4'h0, q, e);
        `CHK("unmapped error", 1'b1, e)
        // Start the main crystal and move onto it, then back to the fast internal oscillator.
        wr(csw_pkg::ADDR_OSC_RUN, 8'h40);
        `CHK("crystal run", 1'b1, osc_run.main_xtal)
        wr(csw_pkg::ADDR_SYS_SEL, 8'h10);
        poll(csw_pkg::ADDR_SYS_SEL, 8'h30);
        apb(1'b1, csw_pkg::ADDR_SYS_SEL, 8'h00, 4'h0, q, e);
        rd(csw_pkg::ADDR_SYS_SEL, 8'h30);
        wr(csw_pkg::ADDR_SYS_SEL, 8'h00);
        poll(csw_pkg::ADDR_SYS_SEL, 8'h00);
        `CHK("main status", 1'b0, main_from_crystal)
        wr(csw_pkg::ADDR_OSC_RUN, 8'hc0);
        `CHK("crystal stop", 1'b0, osc_run.main_xtal)
        // Mid oscillator not yet ready: the pick status must wait for it.
        wr(csw_pkg::ADDR_OSC_RUN, 8'hc2);
        `CHK("mid run", 1'b1, osc_run.mid)
        repeat (csw_pkg::MID_OSC_SETTLE_CYC) @(posedge clock);
        wr(csw_pkg::ADDR_SYS_SEL, 8'h01);
        repeat (5) @(posedge clock);
        rd(csw_pkg::ADDR_SYS_SEL, 8'h01);
        @(posedge clock);
        osc_ready <= 5'h1f;
        poll(csw_pkg::ADDR_SYS_SEL, 8'h03);
        `CHK("pick status", 1'b1, internal_pick_mid)
        wr(csw_pkg::ADDR_OSC_RUN, 8'hc3);
        `CHK("fast stop", 1'b0, osc_run.fast)
        // CPU onto the slow oscillator through the subsystem path.
        wr(csw_pkg::ADDR_SUB_SRC, 8'h01);
        `CHK("slow run", 1'b1, osc_run.slow)
        repeat (csw_pkg::SLOW_OSC_SETTLE_CYC) @(posedge clock);
        wr(csw_pkg::ADDR_SYS_SEL, 8'h41);
        poll(csw_pkg::ADDR_SYS_SEL, 8'hc3);
        `CHK("cpu status", 1'b1, cpu_from_subsystem)
        `CHK("sub from slow", 1'b1, subsys_from_slow)
        wr(csw_pkg::ADDR_SYS_SEL, 8'h51);
        rd(csw_pkg::ADDR_SYS_SEL, 8'hc3);
        // Supply mode bits and their gating of the subsystem clock.
        wr(csw_pkg::ADDR_SUB_SUPPLY, 8'h90);
        rd(csw_pkg::ADDR_SUB_SUPPLY, 8'h90);
        `CHK("timer pick", 1'b1, interval_timer_clock_pick)
        `CHK("periph en", 1'b1, subclk_periph_en)
        @(posedge clock);
        stop_mode <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("periph stop", 1'b0, subclk_periph_en)
        @(posedge clock);
        stop_mode <= 1'b0;
        halt_mode <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("periph halt", 1'b0, subclk_periph_en)
        wr(csw_pkg::ADDR_SYS_SEL, 8'h01);
        poll(csw_pkg::ADDR_SYS_SEL, 8'h03);
        `CHK("periph main", 1'b1, subclk_periph_en)
        @(posedge clock);
        halt_mode <= 1'b0;
        // The external sub clock is already applied, so it needs no settle wait.
        wr(csw_pkg::ADDR_OSC_RUN, 8'h83);
        `CHK("sub xtal run", 1'b1, osc_run.sub_xtal)
        wr(csw_pkg::ADDR_SUB_SRC, 8'h00);
        `CHK("sub from crystal", 1'b0, subsys_from_slow)
        wr(csw_pkg::ADDR_SYS_SEL, 8'h41);
        poll(csw_pkg::ADDR_SYS_SEL, 8'hc3);
        wr(csw_pkg::ADDR_SYS_SEL, 8'h01);
        poll(csw_pkg::ADDR_SYS_SEL, 8'h03);
        // Reserved bits, then back onto the fast oscillator after its settle time.
        wr(csw_pkg::ADDR_OSC_RUN, 8'hbe);
        rd(csw_pkg::ADDR_OSC_RUN, 8'h82);
        repeat (csw_pkg::FAST_OSC_SETTLE_CYC) @(posedge clock);
        wr(csw_pkg::ADDR_SYS_SEL, 8'h0c);
        poll(csw_pkg::ADDR_SYS_SEL, 8'h00);
        // A second reset in mid-run restores the start-up state.
        @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        #1;
        `CHK("osc run reset", 5'h01, osc_run)
        @(posedge clock);
        arst_n <= 1'b1;
        rd(csw_pkg::ADDR_OSC_RUN, csw_pkg::ORC_RESET);
        rd(csw_pkg::ADDR_SYS_SEL, 8'h00);
        close_out();
    end
endmodule : tb_csw_clock_switch
